// >>> src/pipe_lane_ctrl_cfg.svh
// Offsets, field positions, reset values and encodings of the lane control block.
// Assumes inclusion by bare name from the package and the design module.
`ifndef PIPE_LANE_CTRL_CFG_SVH
`define PIPE_LANE_CTRL_CFG_SVH

// ----------------------------------------------------------------------------
// Register byte offsets.
// ----------------------------------------------------------------------------
`define LC_OFS_CTRL      12'h000
`define LC_OFS_EIDLE     12'h004
`define LC_OFS_STATUS    12'h008

// ----------------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------------
`define LC_CTRL_REV_BIT   0
`define LC_CTRL_RATE_LO   1
`define LC_CTRL_MARG_LO   3
`define LC_EIDLE_EN_BIT   0
`define LC_EIDLE_MODE_LO  1
`define LC_MON_REV_BIT    101
`define LC_MON_SEL_LO     98
`define LC_MON_DEEMPH_BIT 97
`define LC_MON_MARG_LO    94
`define LC_MON_RATE_LO    92
`define LC_MON_LANE_W     160

// ----------------------------------------------------------------------------
// Encodings and reset values.
// ----------------------------------------------------------------------------
`define LC_RATE_RSVD     2'h0
`define LC_RATE_GEN1     2'h1
`define LC_RATE_GEN2     2'h2
`define LC_RATE_GEN3     2'h3
`define LC_SEL_NONE      3'h0
`define LC_SEL_COMSKP    3'h4
`define LC_SEL_TS        3'h5
`define LC_SEL_EXIT_UI   3'h6
`define LC_SEL_EXIT_US   3'h7
`define LC_RST_MARGIN    3'h0
`define LC_RST_DEEMPH    1'h0
`define LC_HSIZE_WORD    3'h2
`define LC_HTRANS_NSEQ   2'h2

`endif

// >>> src/pipe_lane_ctrl_pkg.sv
// Types shared by the lane control block and its users.
// Assumes the constants header is on the include path.
package pipe_lane_ctrl_pkg;
  `include "pipe_lane_ctrl_cfg.svh"

  // --------------------------------------------------------------------------
  // Ordered set capability fields, received and advertised.
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic       deemph;
    logic       lane_rev;
    logic [1:0] rate_cap;
  } os_caps_t;

  // --------------------------------------------------------------------------
  // Per-lane PIPE control outputs.
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic       lane_rev;
    logic [2:0] eidle_sel;
    logic       deemph;
    logic [2:0] margin;
    logic [1:0] rate;
  } lane_ctrl_t;

  // --------------------------------------------------------------------------
  // AHB-Lite request bundle.
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic        hsel;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
  } ahb_req_t;

  // --------------------------------------------------------------------------
  // Whole state of the block.
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic       wr_pend;
    logic [1:0] wr_reg;
    logic       infer_en;
    logic [1:0] infer_mode;
    logic       partner_rev;
    lane_ctrl_t lc;
    logic [31:0] rdata;
  } state_t;
endpackage : pipe_lane_ctrl_pkg

// >>> src/pipe_mac_lane_control.sv
// MAC-side per-lane PIPE control: lane reversal, idle inference, de-emphasis,
// margin and rate, with a debug monitor copy. Registers reached over AHB-Lite.
// Assumes one clock, a synchronous reset, and same-clock training logic inputs.
//
// Our own choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "pipe_lane_ctrl_cfg.svh"

// Function
// - Lane reversal output low normal, high reversed.
// - No inference needed drives selector top bit clear.
// - Selector 100: COM/SKP absence, Gen1 or Gen2.
// - Selector 101: TS1/TS2 absence, Gen1 or Gen2.
// - Selector 110: idle exit absence, Gen1/Gen2.
// - Selector 111: idle exit absence, Gen1 only.
// - De-emphasis follows partner training set request.
// - Rate 01 Gen1, 10 Gen2, never 00.
// - Capabilities exchanged in ordered sets, one set shared by all lanes.
module pipe_mac_lane_control #(
  parameter int LANES = 2
) (
  // Clock and reset.
  input  wire logic                           clock_i,
  input  wire logic                           reset_n_i,
  // AHB-Lite slave.
  input  wire pipe_lane_ctrl_pkg::ahb_req_t   ahb_i,
  input  wire logic [31:0]                    hwdata_i,
  output logic [31:0]                         hrdata_o,
  output logic                                hreadyout_o,
  output logic                                hresp_o,
  // Ordered set exchange with training logic.
  input  wire logic                           os_rx_valid_i,
  input  wire pipe_lane_ctrl_pkg::os_caps_t   os_rx_i,
  input  wire logic                           infer_req_i,
  output pipe_lane_ctrl_pkg::os_caps_t        os_tx_o,
  // PIPE lane controls and monitor.
  output pipe_lane_ctrl_pkg::lane_ctrl_t [LANES-1:0] lane_o,
  output logic [LANES*`LC_MON_LANE_W-1:0]     monitor_o
);
  import pipe_lane_ctrl_pkg::*;

  state_t st_r;
  state_t st_nxt;
  logic   addr_ok;
  logic   wr_beat;

  // ------------------------------------------------------------------------
  // Checks whether an inference mode suits a rate.
  // ------------------------------------------------------------------------
  function automatic logic mode_fits(input logic [2:0] sel, input logic [1:0] rate);
    logic fits;
    fits = 1'b0;
    unique case (sel)
      `LC_SEL_COMSKP:  fits = (rate == `LC_RATE_GEN1) || (rate == `LC_RATE_GEN2);
      `LC_SEL_TS:      fits = (rate == `LC_RATE_GEN1) || (rate == `LC_RATE_GEN2);
      `LC_SEL_EXIT_UI: fits = (rate == `LC_RATE_GEN1) || (rate == `LC_RATE_GEN2);
      `LC_SEL_EXIT_US: fits = (rate == `LC_RATE_GEN1);
      default:         fits = 1'b0;
    endcase
    return fits;
  endfunction : mode_fits

  // ------------------------------------------------------------------------
  // Next state.
  // ------------------------------------------------------------------------
  assign addr_ok = ahb_i.hsel && ahb_i.hready && (ahb_i.htrans == `LC_HTRANS_NSEQ)
                   && (ahb_i.hsize == `LC_HSIZE_WORD);
  assign wr_beat = st_r.wr_pend;

  always_comb begin
    logic [2:0] want;
    logic [1:0] new_rate;
    want     = 3'h0;
    new_rate = 2'h0;
    st_nxt   = st_r;
    // A write lands at the edge that ends its data phase.
    st_nxt.wr_pend = addr_ok && ahb_i.hwrite;
    st_nxt.wr_reg  = ahb_i.haddr[3:2];
    if (wr_beat && (st_r.wr_reg == 2'(`LC_OFS_CTRL >> 2))) begin
      st_nxt.lc.lane_rev = hwdata_i[`LC_CTRL_REV_BIT];
      st_nxt.lc.margin   = hwdata_i[`LC_CTRL_MARG_LO +: 3];
      new_rate           = hwdata_i[`LC_CTRL_RATE_LO +: 2];
      // A reserved rate code is dropped so the lanes never carry 00.
      if (new_rate != `LC_RATE_RSVD) begin
        st_nxt.lc.rate = new_rate;
      end
    end
    if (wr_beat && (st_r.wr_reg == 2'(`LC_OFS_EIDLE >> 2))) begin
      st_nxt.infer_en   = hwdata_i[`LC_EIDLE_EN_BIT];
      st_nxt.infer_mode = hwdata_i[`LC_EIDLE_MODE_LO +: 2];
    end
    if (os_rx_valid_i) begin
      st_nxt.lc.deemph   = os_rx_i.deemph;
      st_nxt.partner_rev = os_rx_i.lane_rev;
    end
    want = {1'b1, st_nxt.infer_mode};
    if (st_nxt.infer_en && infer_req_i && mode_fits(want, st_nxt.lc.rate)) begin
      st_nxt.lc.eidle_sel = want;
    end else begin
      st_nxt.lc.eidle_sel = `LC_SEL_NONE;
    end
    // Read data comes from the next state, so a write just ahead is seen.
    st_nxt.rdata = 32'h0;
    if (addr_ok && !ahb_i.hwrite) begin
      unique case (ahb_i.haddr)
        `LC_OFS_CTRL: begin
          st_nxt.rdata[`LC_CTRL_REV_BIT]       = st_nxt.lc.lane_rev;
          st_nxt.rdata[`LC_CTRL_RATE_LO +: 2]  = st_nxt.lc.rate;
          st_nxt.rdata[`LC_CTRL_MARG_LO +: 3]  = st_nxt.lc.margin;
        end
        `LC_OFS_EIDLE: begin
          st_nxt.rdata[`LC_EIDLE_EN_BIT]       = st_nxt.infer_en;
          st_nxt.rdata[`LC_EIDLE_MODE_LO +: 2] = st_nxt.infer_mode;
        end
        `LC_OFS_STATUS: begin
          st_nxt.rdata[0]   = st_nxt.lc.deemph;
          st_nxt.rdata[3:1] = st_nxt.lc.eidle_sel;
          st_nxt.rdata[4]   = st_nxt.partner_rev;
        end
        default: st_nxt.rdata = 32'h0;
      endcase
    end
  end

  // ------------------------------------------------------------------------
  // State register.
  // ------------------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      st_r             <= '0;
      st_r.lc.rate     <= `LC_RATE_GEN1;
      st_r.lc.margin   <= `LC_RST_MARGIN;
      st_r.lc.deemph   <= `LC_RST_DEEMPH;
      st_r.lc.eidle_sel <= `LC_SEL_NONE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------------------
  // Outputs: every lane carries the same controls; monitor slices per lane.
  // ------------------------------------------------------------------------
  assign hrdata_o    = st_r.rdata;
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign os_tx_o     = '{deemph: st_r.lc.deemph, lane_rev: st_r.lc.lane_rev,
                         rate_cap: st_r.lc.rate};

  genvar gi;
  generate
    for (gi = 0; gi < LANES; gi++) begin : g_lane
      localparam int B = gi * `LC_MON_LANE_W;
      assign lane_o[gi] = st_r.lc;
      assign monitor_o[B +: `LC_MON_RATE_LO] = '0;
      assign monitor_o[B + `LC_MON_RATE_LO +: 2]   = st_r.lc.rate;
      assign monitor_o[B + `LC_MON_MARG_LO +: 3]   = st_r.lc.margin;
      assign monitor_o[B + `LC_MON_DEEMPH_BIT]     = st_r.lc.deemph;
      assign monitor_o[B + `LC_MON_SEL_LO +: 3]    = st_r.lc.eidle_sel;
      assign monitor_o[B + `LC_MON_REV_BIT]        = st_r.lc.lane_rev;
      assign monitor_o[B + `LC_MON_REV_BIT + 1 +: 58] = '0;
    end
  endgenerate

  // ------------------------------------------------------------------------
  // Assertions.
  // ------------------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  AST_REV_FOLLOWS_WRITE: assert property (
    wr_beat && st_r.wr_reg == 2'h0 |=> lane_o[0].lane_rev == $past(hwdata_i[0])
  ) else $error("Lane reversal did not follow control write.");
  AST_NO_INFER_TOP_CLEAR: assert property (
    !$past(infer_req_i) |-> !lane_o[0].eidle_sel[2]
  ) else $error("Selector top bit set while no inference wanted.");
  AST_SEL100_RATE: assert property (
    lane_o[0].eidle_sel == 3'h4 |-> lane_o[0].rate inside {2'h1, 2'h2}
  ) else $error("Selector 100 at wrong rate.");
  AST_SEL101_RATE: assert property (
    lane_o[0].eidle_sel == 3'h5 |-> lane_o[0].rate inside {2'h1, 2'h2}
  ) else $error("Selector 101 at wrong rate.");
  AST_SEL110_RATE: assert property (
    lane_o[0].eidle_sel == 3'h6 |-> lane_o[0].rate != 2'h3
  ) else $error("Selector 110 at wrong rate.");
  AST_SEL111_GEN1: assert property (
    lane_o[0].eidle_sel == 3'h7 |-> lane_o[0].rate == 2'h1
  ) else $error("Selector 111 outside first generation.");
  AST_DEEMPH_FROM_TS: assert property (
    os_rx_valid_i |=> lane_o[LANES-1].deemph == $past(os_rx_i.deemph)
  ) else $error("De-emphasis did not take partner request.");
  AST_RATE_NEVER_RSVD: assert property (
    ##1 lane_o[0].rate != 2'h0
  ) else $error("Reserved rate code driven.");
  AST_OS_TX_MATCH: assert property (
    os_tx_o.lane_rev == lane_o[0].lane_rev && os_tx_o.rate_cap == lane_o[0].rate
  ) else $error("Advertised capabilities differ from lane controls.");
  AST_GEN3_CODE: assert property (
    wr_beat && st_r.wr_reg == 2'h0 && hwdata_i[2:1] == 2'h3 |=> lane_o[0].rate == 2'h3
  ) else $error("Third generation rate not encoded as 11.");
  AST_PARTNER_REV_CAPTURE: assert property (
    os_rx_valid_i |=> st_r.partner_rev == $past(os_rx_i.lane_rev)
  ) else $error("Partner lane reversal not captured.");
  AST_TX_DEEMPH: assert property (
    os_rx_valid_i |=> os_tx_o.deemph == $past(os_rx_i.deemph)
  ) else $error("Advertised de-emphasis did not follow training set.");
  AST_DEEMPH_HOLDS: assert property (
    !os_rx_valid_i |=> $stable(lane_o[0].deemph)
  ) else $error("De-emphasis changed without a training set.");
  AST_RSVD_RATE_KEPT: assert property (
    wr_beat && st_r.wr_reg == 2'h0 && hwdata_i[2:1] == 2'h0 |=> $stable(lane_o[0].rate)
  ) else $error("Reserved rate write changed the rate.");
  AST_SEL_NEEDS_ENABLE: assert property (
    lane_o[0].eidle_sel[2] |-> st_r.infer_en && $past(infer_req_i)
  ) else $error("Selector top bit set without an inference request.");
  AST_SEL_FOLLOWS_MODE: assert property (
    lane_o[0].eidle_sel[2] |-> lane_o[0].eidle_sel[1:0] == st_r.infer_mode
  ) else $error("Selector low bits differ from the programmed mode.");

  COV_REVERSED: cover property (lane_o[0].lane_rev ##1 !lane_o[0].lane_rev);
  COV_SEL_COMSKP: cover property (lane_o[0].eidle_sel == 3'h4);
  COV_SEL_TS: cover property (lane_o[0].eidle_sel == 3'h5);
  COV_GEN3: cover property (lane_o[0].rate == 2'h3);
  COV_DEEMPH: cover property (os_rx_valid_i ##1 lane_o[0].deemph);
endmodule : pipe_mac_lane_control
`default_nettype wire

// >>> test/pipe_mac_lane_control_test.sv
// Self-checking bench of the lane control block with a PHY model.
// Assumes the bench is the only AHB master and the slave drives hready.
`timescale 1ns/1ns
`default_nettype none
`include "pipe_lane_ctrl_cfg.svh"
module pipe_mac_lane_control_test;
  import pipe_lane_ctrl_pkg::*;
  localparam int LANES = 2;
  logic                            clock_i     = 1'b0;
  logic                            reset_n_i   = 1'b0;
  logic                            infer_req_i = 1'b0;
  logic                            send        = 1'b0;
  logic [31:0]                     hwdata_i    = '0;
  ahb_req_t                        req         = '0;
  os_caps_t                        caps        = '0;
  logic [15:0]                     rnd         = 16'h0063;
  logic [1:0]                      rate        = 2'h1;
  int                              n_errors    = 0;
  int                              cmp_count   = 0;
  ahb_req_t                        ahb;
  logic [31:0]                     hrdata_o;
  logic [31:0]                     q;
  logic                            hreadyout_o;
  logic                            hresp_o;
  logic                            os_v;
  os_caps_t                        os_rx;
  os_caps_t                        os_tx_o;
  lane_ctrl_t                      exp;
  lane_ctrl_t [LANES-1:0]          lane_o;
  logic [LANES*`LC_MON_LANE_W-1:0] monitor_o;

  always #2 clock_i = ~clock_i;
  always_comb begin
    ahb        = req;
    ahb.hready = hreadyout_o;
  end

  pipe_mac_lane_control #(.LANES(LANES)) u_pipe_mac_lane_control (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .ahb_i(ahb), .hwdata_i(hwdata_i),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .os_rx_valid_i(os_v),
    .os_rx_i(os_rx), .infer_req_i(infer_req_i), .os_tx_o(os_tx_o), .lane_o(lane_o),
    .monitor_o(monitor_o));
  pipe_phy_model u_pipe_phy_model (
    .clock_i(clock_i), .send_i(send), .caps_i(caps), .os_valid_o(os_v), .os_o(os_rx));

  task automatic print_verdict();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, e, g);
    end
  endtask : chk

  // Samples at the falling edge, half a cycle before the rising edge, which equals sampling at that rising edge.
  task automatic wait_rdy(output logic [31:0] d);
    int n;
    n = 0;
    @(negedge clock_i);
    while (hreadyout_o !== 1'b1 && n < 16) begin
      n++;
      @(negedge clock_i);
    end
    if (n == 16) begin
      n_errors++;
      print_verdict();
    end
    d = hrdata_o;
    chk("hresp", 32'h0, 32'(hresp_o));
    @(posedge clock_i);
  endtask : wait_rdy

  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    req <= {1'b1, a, `LC_HTRANS_NSEQ, w, `LC_HSIZE_WORD, 1'b0};
    wait_rdy(rd);
    req      <= '0;
    hwdata_i <= wd;
    wait_rdy(rd);
  endtask : bus

  function automatic logic [2:0] exp_sel(logic [2:0] e, logic r, logic [1:0] rt);
    logic fit;
    fit = (e[2:1] == 2'h3) ? (rt == `LC_RATE_GEN1) :
          (rt == `LC_RATE_GEN1 || rt == `LC_RATE_GEN2);
    return (e[0] && r && fit) ? {1'b1, e[2:1]} : `LC_SEL_NONE;
  endfunction : exp_sel

  function automatic logic [15:0] lfsr(logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr

  initial begin
    repeat (8) @(posedge clock_i);
    reset_n_i <= 1'b1;
    @(negedge clock_i);
    exp = {1'b0, `LC_SEL_NONE, `LC_RST_DEEMPH, `LC_RST_MARGIN, `LC_RATE_GEN1};
    for (int l = 0; l < LANES; l++) chk("lane reset", 32'(exp), 32'(lane_o[l]));
    chk("hrdata reset", 32'h0, hrdata_o);
    @(posedge clock_i);
    for (int i = 0; i < 40; i++) begin
      rnd = lfsr(rnd);
      // The first passes write every rate code, the reserved one first.
      if (i < 4) rnd[2:1] = 2'(i);
      if (rnd[2:1] != `LC_RATE_RSVD) rate = rnd[2:1];
      bus(1'b1, `LC_OFS_CTRL, 32'(rnd[5:0]), q);
      bus(1'b1, `LC_OFS_EIDLE, 32'(rnd[9:7]), q);
      infer_req_i <= rnd[10];
      send        <= 1'b1;
      caps        <= rnd[14:11];
      @(posedge clock_i);
      send <= 1'b0;
      repeat (3) @(posedge clock_i);
      @(negedge clock_i);
      exp = {rnd[0], exp_sel(rnd[9:7], rnd[10], rate), rnd[14], rnd[5:3], rate};
      for (int l = 0; l < LANES; l++) begin
        chk("lane", 32'(exp), 32'(lane_o[l]));
        chk("monitor", 32'(exp), 32'(monitor_o[l*`LC_MON_LANE_W+`LC_MON_RATE_LO +: 10]));
      end
      chk("tx caps", 32'({rnd[14], rnd[0], rate}), 32'(os_tx_o));
      @(posedge clock_i);
      bus(1'b0, `LC_OFS_STATUS, 32'h0, q);
      chk("status", 32'({rnd[13], exp.eidle_sel, rnd[14]}), q);
      bus(1'b0, 12'h00C, 32'h0, q);
      chk("unmapped", 32'h0, q);
    end
    bus(1'b1, 12'h00C, 32'h3F, q);
    @(negedge clock_i);
    chk("unmapped write", 32'(exp), 32'(lane_o[0]));
    @(posedge clock_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    reset_n_i <= 1'b1;
    @(negedge clock_i);
    exp = {1'b0, `LC_SEL_NONE, `LC_RST_DEEMPH, `LC_RST_MARGIN, `LC_RATE_GEN1};
    for (int l = 0; l < LANES; l++) chk("lane rereset", 32'(exp), 32'(lane_o[l]));
    @(posedge clock_i);
    bus(1'b0, `LC_OFS_CTRL, 32'h0, q);
    chk("ctrl rereset", 32'({`LC_RST_MARGIN, `LC_RATE_GEN1, 1'b0}), q);
    print_verdict();
  end
endmodule : pipe_mac_lane_control_test
`default_nettype wire

// >>> test/pipe_phy_model.sv
// PHY-side model that sends training set capabilities to the MAC.
// Assumes the bench raises send_i for one cycle per training set.
`timescale 1ns/1ns
`default_nettype none
module pipe_phy_model (
  // Clock and request.
  input  wire logic                         clock_i,
  input  wire logic                         send_i,
  input  wire pipe_lane_ctrl_pkg::os_caps_t caps_i,
  // Training set capabilities to the MAC.
  output logic                              os_valid_o,
  output pipe_lane_ctrl_pkg::os_caps_t      os_o
);
  import pipe_lane_ctrl_pkg::*;
  initial begin
    os_valid_o = 1'b0;
    os_o       = '0;
  end
  // Idle cycles invert the previous value each cycle, so stale fields are never trusted.
  always @(posedge clock_i) begin
    os_valid_o <= send_i;
    os_o       <= send_i ? caps_i : ~os_o;
  end
endmodule : pipe_phy_model
`default_nettype wire
